// File: logic/uad_top.sv
// serial-port address detect interrupt and power-down / receive-pin wake logic
`timescale 1ns/10ps
`default_nettype none
module uad_top #(
    parameter int BAUD_W         = 16,
    parameter int RESTART_CYCLES = uad_pkg::RESTART_CYCLES
) (
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    input  wire logic                       ce,
    input  wire logic [7:0]                 paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output var  logic [31:0]                prdata,
    output logic                            pready,
    output var  logic                       pslverr,
    input  wire logic                       pwr_down,
    input  wire logic                       rx_pin,
    input  wire logic                       rx_word_valid,
    input  wire logic [uad_pkg::WORD_W-1:0] rx_word,
    input  wire logic                       tx_serial,
    output logic                            tx_pin,
    output logic                            rx_abort,
    output logic                            tx_abort,
    output var  logic                       tx_load,
    output var  logic [uad_pkg::WORD_W-1:0] tx_word,
    output var  logic [BAUD_W-1:0]          baud_div,
    output var  logic                       wake_req,
    output logic                            serial_irq
);
    if (BAUD_W < 1 || BAUD_W > 32) begin : g_bad_baud
        $error("baud divisor width must be 1 to 32");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic top_bit(
        input logic [uad_pkg::WORD_W-1:0] w,
        input logic                       nine
    );
        top_bit = nine ? w[uad_pkg::TOP9_IX] : w[uad_pkg::TOP8_IX];
    endfunction

    logic [uad_pkg::CA_W-1:0]   serial_control_reg_a_q;
    logic [uad_pkg::CB_W-1:0]   serial_control_reg_b_q;
    logic [uad_pkg::IE_W-1:0]   irq_enable_reg_q;
    logic [uad_pkg::WORD_W-1:0] receive_data_reg_q;
    logic                       rx_data_available_flag_q;
    logic                       rx_addr_word_q;
    logic                       stat_seen_q;
    logic                       wake_pend_q;
    logic                       wake_cause_q;
    logic                       wake_arm_q;
    logic                       wake_ack_q;
    uad_pkg::uad_pwr_e          pwr_q;
    uad_pkg::uad_pwr_e          pwr_d;

    // bus decode
    wire setup   = psel & ~penable;
    wire acc     = psel & penable & ce;
    wire wr      = acc & pwrite;
    wire rd      = acc & ~pwrite;
    wire hit_st  = hit(paddr, uad_pkg::OFF_STATUS);
    wire hit_ca  = hit(paddr, uad_pkg::OFF_CTRL_A);
    wire hit_cb  = hit(paddr, uad_pkg::OFF_CTRL_B);
    wire hit_bd  = hit(paddr, uad_pkg::OFF_BAUD);
    wire hit_rx  = hit(paddr, uad_pkg::OFF_RXDATA);
    wire hit_tx  = hit(paddr, uad_pkg::OFF_TXDATA);
    wire hit_ie  = hit(paddr, uad_pkg::OFF_IRQEN);
    wire mapped  = hit_st | hit_ca | hit_cb | hit_bd | hit_rx | hit_tx
                 | hit_ie;
    wire rd_st   = rd & hit_st;
    wire rd_rx   = rd & hit_rx;

    assign pready = psel & penable & ce;

    // control bit aliases
    wire port_en  = serial_control_reg_a_q[uad_pkg::CA_PORT_EN];
    wire nine     = serial_control_reg_a_q[uad_pkg::CA_NINE];
    wire addr_en  = serial_control_reg_b_q[uad_pkg::CB_ADDR_DET];
    wire rx_en    = serial_control_reg_b_q[uad_pkg::CB_RX_EN];
    wire receive_irq_enable      = serial_control_reg_b_q[uad_pkg::CB_RX_IRQ];
    wire wake_en  = serial_control_reg_b_q[uad_pkg::CB_WAKE];
    wire glob_en  = irq_enable_reg_q[uad_pkg::IE_GLOBAL];
    wire ser_en   = irq_enable_reg_q[uad_pkg::IE_SERIAL];
    wire irq_gate = glob_en & ser_en;
    wire running  = (pwr_q == uad_pkg::PWR_RUN);

    // port frozen outside run state, incl. the restart window
    assign rx_abort = ~running;
    assign tx_abort = ~running;
    assign tx_pin   = running ? tx_serial : 1'b1;

    wire rx_take  = ce & rx_word_valid & running & port_en & rx_en;
    // an overrun word is dropped so the unread word is not lost
    wire rx_store = rx_take & ~rx_data_available_flag_q;
    wire rx_clear = rd_rx & stat_seen_q;

    // receive data-available interrupt qualification
    wire rx_irq_req = rx_data_available_flag_q & receive_irq_enable
                    & (~addr_en | rx_addr_word_q);
    assign serial_irq = irq_gate & (rx_irq_req | wake_pend_q);

    // read data mux, captured in the setup phase
    logic [31:0] rd_mux;
    assign rd_mux =
        hit_st ? 32'({running == 1'b0, wake_pend_q, rx_addr_word_q,
                      rx_data_available_flag_q}) :
        hit_ca ? 32'(serial_control_reg_a_q) :
        hit_cb ? 32'(serial_control_reg_b_q) :
        hit_bd ? 32'(baud_div) :
        hit_rx ? 32'(receive_data_reg_q) :
        hit_tx ? 32'(tx_word) :
        hit_ie ? 32'(irq_enable_reg_q) : 32'h0000_0000;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce && setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
        end
    end

    // software registers; none of them is touched by power-down entry
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serial_control_reg_a_q <= uad_pkg::CTRL_A_RST;
            serial_control_reg_b_q <= uad_pkg::CTRL_B_RST;
            irq_enable_reg_q       <= uad_pkg::IRQEN_RST;
            baud_div               <= '0;
            tx_word                <= '0;
            tx_load                <= 1'b0;
        end else if (ce) begin
            tx_load <= wr & hit_tx & running;
            if (wr && hit_ca) begin
                serial_control_reg_a_q <= pwdata[uad_pkg::CA_W-1:0];
            end
            if (wr && hit_cb) begin
                serial_control_reg_b_q <= pwdata[uad_pkg::CB_W-1:0];
            end
            if (wr && hit_ie) begin
                irq_enable_reg_q <= pwdata[uad_pkg::IE_W-1:0];
            end
            if (wr && hit_bd) begin
                baud_div <= pwdata[BAUD_W-1:0];
            end
            if (wr && hit_tx) begin
                tx_word <= pwdata[uad_pkg::WORD_W-1:0];
            end
        end
    end

    // receive holding register and its flags; a new word beats a clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            receive_data_reg_q       <= '0;
            rx_data_available_flag_q <= 1'b0;
            rx_addr_word_q           <= 1'b0;
            stat_seen_q              <= 1'b0;
        end else if (ce) begin
            if (rd_st) begin
                stat_seen_q <= 1'b1;
            end else if (rd_rx) begin
                stat_seen_q <= 1'b0;
            end
            if (rx_store) begin
                receive_data_reg_q       <= rx_word;
                rx_data_available_flag_q <= 1'b1;
                rx_addr_word_q <= top_bit(rx_word, nine);
            end else if (rx_clear) begin
                rx_data_available_flag_q <= 1'b0;
            end
        end
    end

    // power state
    logic restart_busy;
    logic restart_done;
    wire  restart_go = ce & (pwr_q == uad_pkg::PWR_DOWN) & ~pwr_down;
    // a new power-down request during restart wins over the end of it
    wire  restart_ok = restart_done & ~pwr_down
                     & (pwr_q == uad_pkg::PWR_RESTART);

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            uad_pkg::PWR_RUN: begin
                if (pwr_down) pwr_d = uad_pkg::PWR_DOWN;
            end
            uad_pkg::PWR_DOWN: begin
                if (!pwr_down) pwr_d = uad_pkg::PWR_RESTART;
            end
            uad_pkg::PWR_RESTART: begin
                if (restart_ok) pwr_d = uad_pkg::PWR_RUN;
                else if (pwr_down) pwr_d = uad_pkg::PWR_DOWN;
            end
            default: pwr_d = uad_pkg::PWR_RUN;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pwr_q <= uad_pkg::PWR_RUN;
        end else if (ce) begin
            pwr_q <= pwr_d;
        end
    end

    uad_restart #(
        .CYCLES (RESTART_CYCLES)
    ) u_restart (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ce       (ce),
        .start    (restart_go),
        .busy     (restart_busy),
        .done     (restart_done)
    );

    // wake edge catcher: runs from the pin itself since the core clock is
    // stopped; the arm level is static throughout power-down
    wire wake_clr_n = nrst & ~wake_ack_q;
    logic wake_seen;

    always_ff @(negedge rx_pin or negedge wake_clr_n) begin
        if (!wake_clr_n) begin
            wake_req <= 1'b0;
        end else if (wake_arm_q) begin
            wake_req <= 1'b1;
        end
    end

    uad_sync3 u_wake_sync (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .ce        (ce),
        .async_in  (wake_req),
        .level_out (wake_seen)
    );

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wake_arm_q   <= 1'b0;
            wake_ack_q   <= 1'b0;
            wake_cause_q <= 1'b0;
            wake_pend_q  <= 1'b0;
        end else if (ce) begin
            wake_arm_q <= pwr_down & wake_en & port_en & rx_en & receive_irq_enable;
            wake_ack_q <= wake_seen & ~pwr_down;
            if (wake_seen) begin
                wake_cause_q <= 1'b1;
            end else if (restart_done) begin
                wake_cause_q <= 1'b0;
            end
            // set after restart only, and only when interrupts are enabled
            if (restart_ok && wake_cause_q && irq_gate) begin
                wake_pend_q <= 1'b1;
            end else if (rd_st) begin
                wake_pend_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_word_in(bit b);
        rx_store && top_bit(rx_word, nine) == b;
    endsequence

    a_addr_irq_gate: assert property (
        addr_en && !rx_addr_word_q |-> !rx_irq_req)
        else $error("data interrupt on non-address word");
    a_top_bit_pick: assert property (
        s_word_in(1'b1) ##1 ce |-> rx_addr_word_q)
        else $error("address word not marked");
    a_plain_irq: assert property (
        !addr_en && receive_irq_enable && rx_data_available_flag_q |-> rx_irq_req)
        else $error("data interrupt missing without address detect");
    a_irq_gating: assert property (
        serial_irq |-> glob_en && ser_en)
        else $error("interrupt with an enable cleared");
    a_pd_line_high: assert property (
        ce && pwr_down ##1 1'b1 |-> tx_pin && tx_abort)
        else $error("transmit line not held high in power-down");
    a_pd_rx_drop: assert property (
        restart_busy |-> rx_abort && !rx_store)
        else $error("receive word taken during restart");
    a_pd_regs_hold: assert property (
        $rose(pwr_q == uad_pkg::PWR_DOWN) |->
        $stable(serial_control_reg_b_q) && $stable(baud_div))
        else $error("register changed on power-down entry");
    a_wake_irq_late: assert property (
        $rose(wake_pend_q) |-> $past(restart_done) && running)
        else $error("wake interrupt before restart finished");
    a_flag_follows: assert property (
        rx_store |=> rx_data_available_flag_q)
        else $error("data flag not set after word stored");
endmodule
`default_nettype wire

// File: include/uad_pkg.sv
// constants shared by the serial-port address detect and power-down logic
package uad_pkg;
    // register byte offsets on the peripheral bus
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL_A = 8'h04;
    localparam logic [7:0] OFF_CTRL_B = 8'h08;
    localparam logic [7:0] OFF_BAUD   = 8'h0c;
    localparam logic [7:0] OFF_RXDATA = 8'h10;
    localparam logic [7:0] OFF_TXDATA = 8'h14;
    localparam logic [7:0] OFF_IRQEN  = 8'h18;

    // serial_status_reg fields
    localparam int ST_RX_AVAIL  = 0;
    localparam int ST_ADDR_WORD = 1;
    localparam int ST_WAKE_PEND = 2;
    localparam int ST_RESTART   = 3;
    localparam int ST_W         = 4;

    // serial_control_reg_a fields
    localparam int CA_PORT_EN = 0;
    localparam int CA_NINE    = 1;
    localparam int CA_PARITY  = 2;
    localparam int CA_W       = 3;

    // serial_control_reg_b fields
    localparam int CB_ADDR_DET = 0;
    localparam int CB_RX_EN    = 1;
    localparam int CB_RX_IRQ   = 2;
    localparam int CB_WAKE     = 3;
    localparam int CB_W        = 4;

    // interrupt enable register fields
    localparam int IE_GLOBAL = 0;
    localparam int IE_SERIAL = 1;
    localparam int IE_W      = 2;

    // word layout: bit 8 is the ninth bit, bit 7 the eighth
    localparam int WORD_W  = 9;
    localparam int TOP9_IX = 8;
    localparam int TOP8_IX = 7;

    localparam logic [CA_W-1:0] CTRL_A_RST = 3'h0;
    localparam logic [CB_W-1:0] CTRL_B_RST = 4'h0;
    localparam logic [IE_W-1:0] IRQEN_RST  = 2'h0;

    localparam int RESTART_CYCLES = 1024;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_DOWN,
        PWR_RESTART
    } uad_pwr_e;
endpackage

// File: logic/uad_sync3.sv
// three-stage synchroniser that reports a level once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module uad_sync3 (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic async_in,
    output var  logic level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_out <= 1'b0;
        end else if (ce) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_out <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/uad_restart.sv
// restart interval timer run after leaving power-down
`timescale 1ns/10ps
`default_nettype none
module uad_restart #(
    parameter int CYCLES = uad_pkg::RESTART_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic start,
    output var  logic busy,
    output var  logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] seen_q;

    if (CYCLES < 2) begin : g_bad
        $error("restart interval must be at least two cycles");
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                busy  <= 1'b1;
                cnt_q <= '0;
            end else if (busy) begin
                cnt_q <= cnt_q + CW'(1);
                if (cnt_q == LAST) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    // helper: enabled cycles since the last start, saturating
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            seen_q <= '0;
        end else if (ce) begin
            if (start) begin
                seen_q <= CW'(1);
            end else if (seen_q != '1) begin
                seen_q <= seen_q + CW'(1);
            end
        end
    end

    a_restart_len: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(done) |-> seen_q == CW'(CYCLES + 1))
        else $error("restart interval not exactly the set length");
endmodule
`default_nettype wire

// File: sim/uad_line_partner.sv
// remote serial transmitter with its framer, seen at the port inputs
`timescale 1ns/10ps
`default_nettype none
module uad_line_partner #(
    parameter int BIT_CYCLES = 2
) (
    input  wire logic                       core_clk,
    output var  logic                       rx_pin,
    output var  logic                       rx_word_valid,
    output var  logic [uad_pkg::WORD_W-1:0] rx_word
);
    initial begin
        rx_pin        = 1'b1;
        rx_word_valid = 1'b0;
        rx_word       = '0;
    end

    // outside the strobe the word bus shows the inverse, never a stale copy
    task automatic present(input logic [uad_pkg::WORD_W-1:0] w);
        @(posedge core_clk);
        rx_word       <= w;
        rx_word_valid <= 1'b1;
        @(posedge core_clk);
        rx_word_valid <= 1'b0;
        rx_word       <= ~w;
    endtask

    // start bit, data lsb first, one stop bit; line idles high
    task automatic send(input logic [uad_pkg::WORD_W-1:0] w,
                        input logic                       nine);
        int n;
        n = nine ? 9 : 8;
        for (int i = -1; i <= n; i++) begin
            @(posedge core_clk);
            rx_pin <= (i < 0) ? 1'b0 : ((i == n) ? 1'b1 : w[i]);
            repeat (BIT_CYCLES - 1) @(posedge core_clk);
        end
        present(w);
    endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// register-level bench for the address detect and power-down logic
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        core_clk, nrst, ce, psel, penable, pwrite, pwr_down;
    logic        tx_serial, pready, pslverr, rx_pin, rx_word_valid;
    logic        tx_pin, rx_abort, tx_abort, tx_load, wake_req, serial_irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [8:0]  rx_word, tx_word;
    logic [15:0] baud_div;
    logic [12:0] tbl [9];
    logic        rerr;
    int          error_cnt, n_compared, n_load;

    uad_top #(.BAUD_W(16), .RESTART_CYCLES(8)) u_uad_top (
        .core_clk(core_clk), .nrst(nrst), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwr_down(pwr_down), .rx_pin(rx_pin), .rx_word_valid(rx_word_valid),
        .rx_word(rx_word), .tx_serial(tx_serial), .tx_pin(tx_pin),
        .rx_abort(rx_abort), .tx_abort(tx_abort), .tx_load(tx_load),
        .tx_word(tx_word), .baud_div(baud_div), .wake_req(wake_req),
        .serial_irq(serial_irq)
    );

    uad_line_partner #(.BIT_CYCLES(2)) u_uad_line_partner (
        .core_clk(core_clk), .rx_pin(rx_pin),
        .rx_word_valid(rx_word_valid), .rx_word(rx_word)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (tx_load === 1'b1) n_load++;
    end

    task automatic final_report();
        if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // setup edge, then hold everything until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rdat, exp);
    endtask

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    // one trip through power-down, with a receive-pin edge sent while down; left by releasing pwr_down
    task automatic pd_cycle(input logic armed, input logic ie);
        int n;
        apb(1'b1, uad_pkg::OFF_CTRL_B, {28'h0, armed, 3'h6});
        apb(1'b1, uad_pkg::OFF_IRQEN, ie ? 32'h3 : 32'h0);
        @(posedge core_clk);
        tx_serial <= 1'b0;
        tick();
        check("tx_pin run", tx_pin, 32'h0);
        @(posedge core_clk);
        pwr_down <= 1'b1;
        repeat (3) tick();
        check("tx_pin down", tx_pin, 32'h1);
        check("tx_abort", tx_abort, 32'h1);
        check("rx_abort", rx_abort, 32'h1);
        rd_chk("status down", uad_pkg::OFF_STATUS, 32'h8);
        @(posedge core_clk);
        ce <= 1'b0;
        u_uad_line_partner.send(9'h0a5, 1'b1);
        #1;
        check("wake_req", wake_req, armed);
        @(posedge core_clk);
        ce       <= 1'b1;
        pwr_down <= 1'b0;
        // a word offered during the restart interval must be dropped
        u_uad_line_partner.present(9'h1c3);
        for (int i = 0; i < 5; i++) begin
            tick();
            check("irq restart", serial_irq, 32'h0);
            check("abort restart", rx_abort, 32'h1);
        end
        for (n = 0; n < 40 && serial_irq !== 1'b1; n++) tick();
        check("wake irq", serial_irq, armed & ie);
        check("run again", rx_abort, 32'h0);
        apb(1'b0, uad_pkg::OFF_STATUS, 32'h0);
        check("status wake", rdat, {1'b0, armed & ie, 2'b0});
        tick();
        check("irq cleared", serial_irq, 32'h0);
        check("wake_req ack", wake_req, 32'h0);
        @(posedge core_clk);
        tx_serial <= 1'b1;
    endtask

    initial begin
        #100000;
        error_cnt++;
        final_report();
    end

    initial begin
        logic [8:0] w;
        logic       nine;
        logic       top;
        nrst = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; pwr_down = 1'b0; tx_serial = 1'b1;
        error_cnt = 0; n_compared = 0; n_load = 0;
        // {address detect, nine-bit, irq enables, expected irq, word}
        tbl = '{{4'he, 9'h055}, {4'hf, 9'h155}, {4'he, 9'h0ff},
                {4'hf, 9'h100}, {4'hb, 9'h080}, {4'ha, 9'h17f},
                {4'hc, 9'h100}, {4'h7, 9'h055}, {4'h3, 9'h000}};
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        rd_chk("ctrl_a rst", uad_pkg::OFF_CTRL_A, 32'h0);
        rd_chk("ctrl_b rst", uad_pkg::OFF_CTRL_B, 32'h0);
        rd_chk("irqen rst", uad_pkg::OFF_IRQEN, 32'h0);
        rd_chk("status rst", uad_pkg::OFF_STATUS, 32'h0);
        rd_chk("unmapped", 8'h1c, 32'h0);
        check("pslverr", rerr, 32'h1);
        apb(1'b1, uad_pkg::OFF_BAUD, 32'h1234);
        apb(1'b1, uad_pkg::OFF_TXDATA, 32'h1a5);
        tick();
        check("baud_div", baud_div, 32'h1234);
        check("tx_word", tx_word, 32'h1a5);
        check("tx_load", n_load, 32'h1);
        for (int k = 0; k < 9; k++) begin
            w    = tbl[k][8:0];
            nine = tbl[k][11];
            top  = nine ? w[uad_pkg::TOP9_IX] : w[uad_pkg::TOP8_IX];
            // parity stays off throughout
            apb(1'b1, uad_pkg::OFF_CTRL_A, {30'h0, nine, 1'b1});
            apb(1'b1, uad_pkg::OFF_CTRL_B, {29'h3, tbl[k][12]});
            apb(1'b1, uad_pkg::OFF_IRQEN, tbl[k][10] ? 32'h3 : 32'h0);
            u_uad_line_partner.send(w, nine);
            tick();
            check("rx irq", serial_irq, tbl[k][9]);
            rd_chk("status word", uad_pkg::OFF_STATUS, {top, 1'b1});
            apb(1'b0, uad_pkg::OFF_RXDATA, 32'h0);
            check("rxdata", rdat, w);
            // the address mark describes the held word and outlives the read
            rd_chk("status empty", uad_pkg::OFF_STATUS, {top, 1'b0});
            check("irq gone", serial_irq, 32'h0);
        end
        pd_cycle(1'b0, 1'b1);
        pd_cycle(1'b1, 1'b1);
        pd_cycle(1'b1, 1'b0);
        rd_chk("ctrl_a kept", uad_pkg::OFF_CTRL_A, 32'h1);
        rd_chk("ctrl_b kept", uad_pkg::OFF_CTRL_B, 32'he);
        rd_chk("baud kept", uad_pkg::OFF_BAUD, 32'h1234);
        rd_chk("txdata kept", uad_pkg::OFF_TXDATA, 32'h1a5);
        check("tx_load none", n_load, 32'h1);
        // reset again in mid-run: control register b, status and the interrupt must return to their idle values
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd_chk("ctrl_b re-rst", uad_pkg::OFF_CTRL_B, 32'h0);
        rd_chk("status re-rst", uad_pkg::OFF_STATUS, 32'h0);
        check("irq re-rst", serial_irq, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
